// ---- src/alu_hash.v ----
// bucket hash shared by frame lookups and software access by mac address
// assumes inputs come from registers on the same clock
`timescale 1ns/10ps
module lookup_hash (
  input  wire [47:0] mac,    // mac address key
  input  wire [6:0]  filter_group_id,    // filter group id
  input  wire        fid_en, // fold filter group id into the hash
  input  wire [1:0]  opt,    // hash option
  output reg  [9:0]  bucket  // bucket index
);
  reg [9:0] fold;
  reg [9:0] fterm;
  always @* begin
    fterm = fid_en ? {3'h0, filter_group_id} : 10'h000;
    fold  = mac[9:0] ^ mac[19:10] ^ mac[29:20] ^ mac[39:30] ^ {2'h0, mac[47:40]} ^ fterm;
    case (opt)
      2'h1: bucket = {fold[4:0], fold[9:5]};
      2'h2: bucket = mac[9:0] ^ fterm;
      default: bucket = fold;
    endcase
  end
endmodule // lookup_hash

// ---- src/alu_table_map.vh ----
// register map, field positions and constants of the mac address lookup table
// assumes 32-bit axi4-lite access with byte addresses in the low 12 bits
`ifndef LOOKUP_TABLE_MAP_VH
`define LOOKUP_TABLE_MAP_VH
`define OFF_IDX0      12'h410
`define OFF_IDX1      12'h414
`define OFF_CTRL      12'h418
`define OFF_EVT       12'h41c
`define OFF_ENT1      12'h420
`define OFF_ENT2      12'h424
`define OFF_ENT3      12'h428
`define OFF_ENT4      12'h42c
`define OFF_EIDX0     12'h430
`define OFF_EIDX1     12'h434
`define OFF_CFG       12'h438
`define CTL_GO        31
`define CTL_FOUND     30
`define CTL_ANY       29
`define CTL_DIRECT    2
`define ACT_WRITE     2'h1
`define ACT_READ      2'h2
`define ACT_SEARCH    2'h3
`define EVT_AF        2
`define EVT_WF        1
`define EVT_LF        0
`define E_STATIC      71
`define E_SRCF        70
`define E_DESF        69
`define AGE_DEFAULT   3'h7
`define LAST_LOC      12'hfff
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// ---- src/bucket_ram.v ----
// 1k buckets of four 72-bit ways, one bucket read per cycle, per-way write
// assumes caller holds bucket stable from read to write
`timescale 1ns/10ps
module bucket_ram (
  input  wire         clk,      // core clock
  input  wire         ce,       // clock enable
  input  wire [9:0]   bucket,   // bucket address for read and write
  input  wire [3:0]   way_we,   // write enable per way
  input  wire [71:0]  wr_entry, // entry to write
  output wire [287:0] q         // registered bucket contents, way 0 low
);
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : way
      reg [71:0] mem [0:1023];
      reg [71:0] q_reg;
      always @(posedge clk) begin
        if (ce) begin
          if (way_we[g])
            mem[bucket] <= wr_entry;
          q_reg <= mem[bucket];
        end
      end
      assign q[g*72 +: 72] = q_reg;
    end
  endgenerate
endmodule // bucket_ram

// ---- src/mac_address_lookup_table.v ----
// hashed 4-way mac address lookup table with learning, forwarding lookup
// and software read, write and search over axi4-lite
// assumes frame lookup requests are levels held until the matching done pulse
//
// Summary of operation
// - table is 1k buckets of four ways, 4k entries
// - mac plus optional filter group id hash to a 10-bit bucket
// - insert into free way, else replace least recently used dynamic way
// - static add to bucket with 2 or 3 statics flags almost full, index 0
// - hashed static add to four-static bucket fails, flags write fail, bucket in index 0
// - four-static bucket blocks learning, flags learn fail, bucket in index 1
// - source lookups learn here; destination lookups merge all tables
// - static destination match wins over dynamic match
// - software reads any entry, writes static entries only
// - software access by mac uses the shared hash with hash option
// - direct location in mac field bits 11:0 replaces the hash
// - action 10 reads by mac, filter group id or direct location
// - action 01 writes entry registers by chosen addressing method
// - action 11 is a read-only sequential search of valid entries
// - go bit clears when read or write completes; found shows result
// - combined bit from go and found for single-bit polling
// - read miss or search end returns zeros in entry registers
// - search starts at top, skips invalid, clears then sets found
// - reading entry register four resumes the search
// - go stays set through search; writing zero aborts
// - count of valid entries found is readable
`timescale 1ns/10ps
`include "alu_table_map.vh"
module mac_address_lookup_table (
  input  wire        core_clk,       // switch core clock
  input  wire        rst,            // synchronous reset
  input  wire        ce,             // clock enable, freezes state when low
  input  wire [11:0] s_axi_awaddr,   // write address
  input  wire        s_axi_awvalid,  // write address valid
  output reg         s_axi_awready,  // write address ready
  input  wire [31:0] s_axi_wdata,    // write data
  input  wire [3:0]  s_axi_wstrb,    // write byte strobes
  input  wire        s_axi_wvalid,   // write data valid
  output reg         s_axi_wready,   // write data ready
  output reg  [1:0]  s_axi_bresp,    // write response
  output reg         s_axi_bvalid,   // write response valid
  input  wire        s_axi_bready,   // write response ready
  input  wire [11:0] s_axi_araddr,   // read address
  input  wire        s_axi_arvalid,  // read address valid
  output reg         s_axi_arready,  // read address ready
  output reg  [31:0] s_axi_rdata,    // read data
  output reg  [1:0]  s_axi_rresp,    // read response
  output reg         s_axi_rvalid,   // read data valid
  input  wire        s_axi_rready,   // read data ready
  input  wire        sa_req,         // source lookup request level
  input  wire [47:0] sa_mac,         // source mac
  input  wire [6:0]  sa_fid,         // source filter group id
  input  wire [6:0]  sa_port,        // ingress port one-hot
  output reg         sa_done,        // source lookup done pulse
  output reg         sa_drop,        // drop frame on source filter
  input  wire        da_req,         // destination lookup request level
  input  wire [47:0] da_mac,         // destination mac
  input  wire [6:0]  da_fid,         // destination filter group id
  input  wire        ext_static_hit, // static hit from the other address tables
  input  wire [6:0]  ext_static_fwd, // forward map of that static hit
  output reg         da_done,        // destination lookup done pulse
  output reg         da_hit,         // destination found in some table
  output reg  [6:0]  da_fwd,         // forward port map
  output reg         da_drop         // drop frame on destination filter
);
  localparam S_IDLE = 2'h0, S_HASH = 2'h1, S_RD = 2'h2, S_EVAL = 2'h3;
  localparam K_DA = 2'h0, K_SA = 2'h1, K_SW = 2'h2;

  reg [1:0]  state_reg;
  reg [1:0]  kind_reg;
  reg [47:0] key_mac_reg;
  reg [6:0]  key_fid_reg;
  reg [6:0]  key_port_reg;
  reg [9:0]  bucket_reg;
  reg [22:0] idx0_reg;
  reg [31:0] idx1_reg;
  reg [1:0]  action_reg;
  reg        direct_reg;
  reg        go_reg;
  reg        found_reg;
  reg        hold_reg;
  reg [12:0] count_reg;
  reg [11:0] ptr_reg;
  reg [71:0] ent_reg;
  reg [2:0]  evt_reg;
  reg [11:0] eidx0_reg;
  reg [9:0]  eidx1_reg;
  reg [1:0]  hash_opt_reg;
  reg        fid_en_reg;

  wire [11:0] loc = idx1_reg[11:0];
  wire        wr_fire = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
  wire        rd_fire = s_axi_arready & s_axi_arvalid;

  function [32:0] reg_word;
    input [11:0] a;
    begin
      case (a)
        `OFF_IDX0:  reg_word = {1'b0, 9'h000, idx0_reg};
        `OFF_IDX1:  reg_word = {1'b0, idx1_reg};
        `OFF_CTRL:  reg_word = {1'b0, go_reg, found_reg, found_reg | ~go_reg, count_reg,
                                13'h0000, direct_reg, action_reg};
        `OFF_EVT:   reg_word = {1'b0, 29'h00000000, evt_reg};
        `OFF_ENT1:  reg_word = {1'b0, ent_reg[71:66], 23'h000000, ent_reg[65:63]};
        `OFF_ENT2:  reg_word = {1'b0, ent_reg[62], 24'h000000, ent_reg[61:55]};
        `OFF_ENT3:  reg_word = {1'b0, 9'h000, ent_reg[54:32]};
        `OFF_ENT4:  reg_word = {1'b0, ent_reg[31:0]};
        `OFF_EIDX0: reg_word = {1'b0, 20'h00000, eidx0_reg};
        `OFF_EIDX1: reg_word = {1'b0, 22'h000000, eidx1_reg};
        `OFF_CFG:   reg_word = {1'b0, 29'h00000000, fid_en_reg, hash_opt_reg};
        default:    reg_word = {1'b1, 32'h00000000};
      endcase
    end
  endfunction

  wire [32:0] wcur  = reg_word(s_axi_awaddr);
  wire [32:0] rword = reg_word(s_axi_araddr);
  wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                       {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] wd    = (wcur[31:0] & ~wmask) | (s_axi_wdata & wmask);

  wire [9:0] hash_bucket;
  lookup_hash u_hash (
    .mac    (key_mac_reg),
    .filter_group_id    (key_fid_reg),
    .fid_en (fid_en_reg),
    .opt    (hash_opt_reg),
    .bucket (hash_bucket)
  );

  wire [287:0] bucket_q;
  reg  [3:0]   way_we;
  reg  [71:0]  wr_entry;
  bucket_ram u_ram (
    .clk      (core_clk),
    .ce       (ce),
    .bucket   (bucket_reg),
    .way_we   (way_we),
    .wr_entry (wr_entry),
    .q        (bucket_q)
  );

  wire [3:0]  wv;
  wire [3:0]  ws;
  wire [3:0]  wm;
  wire [71:0] way_e [0:3];
  wire [2:0]  wage [0:3];
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : way
      assign way_e[g] = bucket_q[g*72 +: 72];
      assign wage[g]  = way_e[g][68:66];
      assign wv[g] = way_e[g][`E_STATIC] | (wage[g] != 3'h0);
      assign ws[g] = way_e[g][`E_STATIC];
      assign wm[g] = wv[g] & (way_e[g][47:0] == key_mac_reg) &
                     (~fid_en_reg | (way_e[g][54:48] == key_fid_reg));
    end
  endgenerate

  reg       hit, hs, free, dfound;
  reg [1:0] hway, fway, lway;
  reg [2:0] lage, scnt;
  integer   i;
  // pick hit, free and lru ways
  always @* begin
    hit = 1'b0; hs = 1'b0; free = 1'b0; dfound = 1'b0;
    hway = 2'h0; fway = 2'h0; lway = 2'h0; lage = 3'h7; scnt = 3'h0;
    for (i = 0; i < 4; i = i + 1) begin
      if (wm[i] && !hs && (!hit || ws[i])) begin
        hit = 1'b1;
        hs = ws[i];
        hway = i[1:0];
      end
      if (!wv[i] && !free) begin
        free = 1'b1;
        fway = i[1:0];
      end
      if (wv[i] && !ws[i] && (!dfound || wage[i] < lage)) begin
        dfound = 1'b1;
        lway = i[1:0];
        lage = wage[i];
      end
      if (ws[i])
        scnt = scnt + 3'h1;
    end
  end

  wire [1:0] ins_way = hit ? hway : (free ? fway : lway);
  wire [1:0] sw_way  = direct_reg ? loc[1:0] : ins_way;
  wire       sw_ok   = direct_reg | hit | free | dfound;
  wire [1:0] rd_way  = direct_reg ? loc[1:0] : hway;
  wire       rd_ok   = direct_reg ? wv[loc[1:0]] : hit;

  reg lf_set, wf_set, af_set;
  always @* begin
    way_we = 4'h0; wr_entry = 72'h0; lf_set = 1'b0; wf_set = 1'b0; af_set = 1'b0;
    if (state_reg == S_EVAL) begin
      case (kind_reg)
        K_SA: begin
          if (hit) begin
            if (!hs) begin
              way_we[hway] = 1'b1;
              wr_entry = {way_e[hway][71:69], `AGE_DEFAULT, way_e[hway][65:62],
                          key_port_reg, way_e[hway][54:0]};
            end
          end else if (free || dfound) begin
            way_we[ins_way] = 1'b1;
            wr_entry = {3'h0, `AGE_DEFAULT, 3'h0, 1'b0, key_port_reg, key_fid_reg, key_mac_reg};
          end else begin
            lf_set = 1'b1;
          end
        end
        K_SW: begin
          if (action_reg == `ACT_WRITE && go_reg && ent_reg[`E_STATIC]) begin
            if (sw_ok) begin
              way_we[sw_way] = 1'b1;
              wr_entry = ent_reg;
              if (!ws[sw_way] && (scnt == 3'h2 || scnt == 3'h3))
                af_set = 1'b1;
            end else begin
              wf_set = 1'b1;
            end
          end
        end
        default: begin
          way_we = 4'h0;
        end
      endcase
    end
  end

  // event flags, set wins over write-one-to-clear
  always @(posedge core_clk) begin
    if (rst) begin
      evt_reg <= 3'h0;
    end else if (ce) begin
      evt_reg <= (evt_reg & ~((wr_fire && s_axi_awaddr == `OFF_EVT) ? wd[2:0] : 3'h0)) |
                 {af_set, wf_set, lf_set};
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wcur[32] ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rword[31:0];
        s_axi_rresp  <= rword[32] ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      state_reg <= S_IDLE; kind_reg <= K_DA; key_mac_reg <= 48'h0; key_fid_reg <= 7'h00;
      key_port_reg <= 7'h00; bucket_reg <= 10'h000; idx0_reg <= 23'h0; idx1_reg <= 32'h0;
      action_reg <= 2'h0; direct_reg <= 1'b0; go_reg <= 1'b0; found_reg <= 1'b0;
      hold_reg <= 1'b0; count_reg <= 13'h0000; ptr_reg <= 12'h000; ent_reg <= 72'h0;
      eidx0_reg <= 12'h000; eidx1_reg <= 10'h000; hash_opt_reg <= 2'h0; fid_en_reg <= 1'b0;
      sa_done <= 1'b0; sa_drop <= 1'b0; da_done <= 1'b0; da_hit <= 1'b0;
      da_fwd <= 7'h00; da_drop <= 1'b0;
    end else if (ce) begin
      sa_done <= 1'b0;
      da_done <= 1'b0;
      if (wr_fire) begin
        case (s_axi_awaddr)
          `OFF_IDX0: idx0_reg <= wd[22:0];
          `OFF_IDX1: idx1_reg <= wd;
          `OFF_CTRL: begin
            if (go_reg) begin
              if (!wd[`CTL_GO]) begin
                go_reg <= 1'b0;
                hold_reg <= 1'b0;
              end
            end else begin
              action_reg <= wd[1:0];
              direct_reg <= wd[`CTL_DIRECT];
              go_reg <= wd[`CTL_GO];
              if (wd[`CTL_GO]) begin
                found_reg <= 1'b0;
                hold_reg <= 1'b0;
                ptr_reg <= 12'h000;
                if (wd[1:0] == `ACT_SEARCH)
                  count_reg <= 13'h0000;
              end
            end
          end
          `OFF_ENT1: begin
            ent_reg[71:66] <= wd[31:26];
            ent_reg[65:63] <= wd[2:0];
          end
          `OFF_ENT2: begin
            ent_reg[62] <= wd[31];
            ent_reg[61:55] <= wd[6:0];
          end
          `OFF_ENT3: ent_reg[54:32] <= wd[22:0];
          `OFF_ENT4: ent_reg[31:0] <= wd;
          `OFF_CFG: begin
            hash_opt_reg <= wd[1:0];
            fid_en_reg <= wd[2];
          end
          default: ;
        endcase
      end
      if (rd_fire && s_axi_araddr == `OFF_ENT4 && hold_reg) begin
        hold_reg <= 1'b0;
        found_reg <= 1'b0;
        if (ptr_reg == `LAST_LOC) begin
          go_reg <= 1'b0;
          ent_reg <= 72'h0;
        end else
          ptr_reg <= ptr_reg + 12'h001;
      end
      case (state_reg)
        S_IDLE: begin
          if (da_req && !da_done) begin
            key_mac_reg <= da_mac;
            key_fid_reg <= da_fid;
            kind_reg <= K_DA;
            state_reg <= S_HASH;
          end else if (sa_req && !sa_done) begin
            key_mac_reg <= sa_mac;
            key_fid_reg <= sa_fid;
            key_port_reg <= sa_port;
            kind_reg <= K_SA;
            state_reg <= S_HASH;
          end else if (go_reg && !hold_reg) begin
            key_mac_reg <= (action_reg == `ACT_WRITE) ? ent_reg[47:0] : {idx0_reg[15:0], idx1_reg};
            key_fid_reg <= (action_reg == `ACT_WRITE) ? ent_reg[54:48] : idx0_reg[22:16];
            kind_reg <= K_SW;
            state_reg <= S_HASH;
          end
        end
        S_HASH: begin
          if (kind_reg == K_SW && action_reg == `ACT_SEARCH)
            bucket_reg <= ptr_reg[11:2];
          else if (kind_reg == K_SW && direct_reg)
            bucket_reg <= loc[11:2];
          else
            bucket_reg <= hash_bucket;
          state_reg <= S_RD;
        end
        S_RD: state_reg <= S_EVAL;
        default: begin
          state_reg <= S_IDLE;
          case (kind_reg)
            K_DA: begin
              da_done <= 1'b1;
              if (hs || (hit && !ext_static_hit)) begin
                da_hit <= 1'b1;
                da_fwd <= way_e[hway][61:55];
                da_drop <= way_e[hway][`E_DESF];
              end else begin
                da_hit <= ext_static_hit;
                da_fwd <= ext_static_hit ? ext_static_fwd : 7'h00;
                da_drop <= 1'b0;
              end
            end
            K_SA: begin
              sa_done <= 1'b1;
              sa_drop <= hit & way_e[hway][`E_SRCF];
              if (lf_set)
                eidx1_reg <= bucket_reg;
            end
            default: begin
              case (action_reg)
                `ACT_READ: begin
                  go_reg <= 1'b0;
                  found_reg <= rd_ok;
                  ent_reg <= rd_ok ? way_e[rd_way] : 72'h0;
                end
                `ACT_WRITE: begin
                  go_reg <= 1'b0;
                  found_reg <= sw_ok & ent_reg[`E_STATIC];
                  if (af_set)
                    eidx0_reg <= {bucket_reg, sw_way};
                  if (wf_set)
                    eidx0_reg <= {2'h0, bucket_reg};
                end
                `ACT_SEARCH: begin
                  if (wv[ptr_reg[1:0]]) begin
                    ent_reg <= way_e[ptr_reg[1:0]];
                    found_reg <= 1'b1;
                    hold_reg <= 1'b1;
                    count_reg <= count_reg + 13'h0001;
                  end else if (ptr_reg == `LAST_LOC) begin
                    go_reg <= 1'b0;
                    ent_reg <= 72'h0;
                  end else
                    ptr_reg <= ptr_reg + 12'h001;
                end
                default: go_reg <= 1'b0;
              endcase
            end
          endcase
        end
      endcase
      if (state_reg != S_IDLE && kind_reg == K_SW && !go_reg)
        state_reg <= S_IDLE;
    end
  end
endmodule // mac_address_lookup_table

// ---- tb/mac_address_lookup_table_tb.sv ----
// self-checking bench for the mac address lookup table
// assumes the map header and the bound checker; table filled with statics first
`timescale 1ns/10ps
`include "alu_table_map.vh"
module mac_address_lookup_table_tb;
  localparam [1:0]  OK  = `RESP_OKAY;
  localparam [1:0]  ER  = `RESP_SLVERR;
  localparam [31:0] ALL = 32'hffffffff;
  localparam [31:0] E1  = 32'h9c000005;
  localparam [31:0] E2  = 32'h8000002a;
  localparam [31:0] E3  = 32'h00151234;
  reg         core_clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  reg         saq = 1'b0, daq = 1'b0, xh = 1'b0;
  reg  [11:0] aw = 12'h0, ar = 12'h0;
  reg  [31:0] wd = 32'h0, x = 32'd99, rdv, r, k;
  reg  [47:0] m = 48'h0, mc;
  reg  [6:0]  xf = 7'h0;
  reg  [65:0] q[$];
  reg  [15:0] dq[$];
  reg  [65:0] nt;
  reg  [15:0] dn;
  integer     errors = 0, compares = 0, guard = 0, i;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        sa_done, da_done, da_hit, sa_drop, da_drop;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [6:0]  da_fwd;
  mac_address_lookup_table uut (.core_clk(core_clk), .rst(rst), .ce(1'b1), .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready, .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr(ar),
    .s_axi_arvalid(arv), .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready(1'b1), .sa_req(saq), .sa_mac(m), .sa_fid(m[6:0]), .sa_port(7'h01), .sa_done,
    .sa_drop, .da_req(daq), .da_mac(m), .da_fid(m[13:7]), .ext_static_hit(xh),
    .ext_static_fwd(xf), .da_done, .da_hit, .da_fwd, .da_drop);
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task report_and_stop;
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task die;
    errors = errors + 1;
    report_and_stop;
  endtask
  task tick;
    @(posedge core_clk);
    guard = guard + 1;
    if (guard > 200)
      die;
  endtask
  task chk(input [33:0] got, input [33:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    rnd = x;
  endfunction
  task wr(input [11:0] a, input [31:0] d, input [1:0] e);
    q.push_back({e, 64'h0});
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    guard = 0;
    tick;
    while (!s_axi_awready) tick;
    awv <= 1'b0;
    wv <= 1'b0;
    while (!s_axi_bvalid) tick;
  endtask
  task rd(input [11:0] a, input [31:0] e, input [31:0] mk, input [1:0] re);
    q.push_back({re, e, mk});
    ar <= a;
    arv <= 1'b1;
    guard = 0;
    tick;
    while (!s_axi_arready) tick;
    arv <= 1'b0;
    while (!s_axi_rvalid) tick;
    rdv = s_axi_rdata;
  endtask
  task poll(input integer b, input v);
    integer n;
    rdv[b] = ~v;
    for (n = 0; n < 60 && rdv[b] !== v; n = n + 1)
      rd(`OFF_CTRL, 32'h0, 32'h0, OK);
    if (rdv[b] !== v)
      die;
  endtask
  task rent(input [31:0] a, input [31:0] b, input [31:0] c, input [31:0] d);
    rd(`OFF_ENT1, a, ALL, OK);
    rd(`OFF_ENT2, b, ALL, OK);
    rd(`OFF_ENT3, c, ALL, OK);
    rd(`OFF_ENT4, d, ALL, OK);
  endtask
  task look(input s, input [47:0] mac);
    guard = 0;
    tick;
    m <= mac;
    saq <= s;
    daq <= !s;
    tick;
    while (!sa_done && !da_done) tick;
    saq <= 1'b0;
    daq <= 1'b0;
  endtask
  // each bus answer or destination lookup result takes the oldest note of its queue
  always @(posedge core_clk) begin
    if (s_axi_bvalid || s_axi_rvalid) begin
      nt = q.pop_front();
      chk({s_axi_bvalid ? s_axi_bresp : s_axi_rresp, s_axi_rdata & nt[31:0]},
          {nt[65:64], nt[63:32] & nt[31:0]});
    end
    if (da_done) begin
      dn = dq.pop_front();
      chk({25'h0, da_drop, {da_hit, da_fwd} & dn[7:0]}, {26'h0, dn[15:8] & dn[7:0]});
    end
    // only misses are looked up, so no filter applies
    if (sa_done)
      chk({33'h0, sa_drop}, 34'h0);
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(`OFF_CTRL, 32'h20000000, ALL, OK);
    rd(12'h000, 32'h0, ALL, ER);
    wr(12'h000, 32'h1, ER);
    wr(`OFF_ENT1, E1, OK);
    wr(`OFF_ENT2, E2, OK);
    wr(`OFF_ENT3, E3, OK);
    // fill every location with a static entry whose low mac is its location
    for (i = 0; i < 4096; i = i + 1) begin
      wr(`OFF_ENT4, i, OK);
      wr(`OFF_IDX1, i, OK);
      wr(`OFF_CTRL, 32'h80000005, OK);
      poll(31, 1'b0);
    end
    wr(`OFF_EVT, 32'h7, OK);
    r = rnd();
    k = {20'h0, r[11:0]};
    wr(`OFF_IDX1, k, OK);
    wr(`OFF_CTRL, 32'h80000006, OK);
    poll(31, 1'b0);
    rd(`OFF_CTRL, 32'h60000000, 32'he0000000, OK);
    rent(E1, E2, E3, k);
    wr(`OFF_ENT1, 32'h1c000000, OK);
    wr(`OFF_ENT4, k, OK);
    wr(`OFF_CTRL, 32'h80000005, OK);
    poll(31, 1'b0);
    rd(`OFF_CTRL, 32'h20000000, 32'he0000000, OK);
    wr(`OFF_CTRL, 32'h80000006, OK);
    poll(31, 1'b0);
    rent(E1, E2, E3, k);
    r = rnd();
    mc = {1'b1, r[14:0], rnd()};
    wr(`OFF_IDX0, {16'h0, mc[47:32]}, OK);
    wr(`OFF_IDX1, mc[31:0], OK);
    wr(`OFF_CTRL, 32'h80000002, OK);
    poll(31, 1'b0);
    rd(`OFF_CTRL, 32'h20000000, 32'he0000000, OK);
    rent(32'h0, 32'h0, 32'h0, 32'h0);
    look(1'b1, mc);
    rd(`OFF_EVT, 32'h1, 32'h7, OK);
    wr(`OFF_EVT, 32'h7, OK);
    rd(`OFF_EVT, 32'h0, 32'h7, OK);
    // the read miss zeroed the entry registers, so the static bit is set again
    wr(`OFF_ENT1, E1, OK);
    wr(`OFF_ENT3, {16'h0, mc[47:32]}, OK);
    wr(`OFF_ENT4, mc[31:0], OK);
    wr(`OFF_CTRL, 32'h80000001, OK);
    poll(31, 1'b0);
    rd(`OFF_EVT, 32'h2, 32'h7, OK);
    for (i = 0; i < 4; i = i + 1) begin
      r = rnd();
      xh <= r[0];
      xf <= r[7:1];
      dq.push_back({r[0], r[7:1], 1'b1, {7{r[0]}}});
      look(1'b0, {1'b1, r[14:0], rnd()});
    end
    wr(`OFF_CTRL, 32'h80000003, OK);
    poll(30, 1'b1);
    rent(E1, E2, E3, 32'h0);
    poll(30, 1'b1);
    rd(`OFF_CTRL, 32'he0020000, 32'hffff0000, OK);
    rent(E1, E2, E3, 32'h1);
    wr(`OFF_CTRL, 32'h0, OK);
    rd(`OFF_CTRL, 32'h0, 32'h80000000, OK);
    report_and_stop;
  end
endmodule // mac_address_lookup_table_tb

// ---- tb/mac_lut_checker.sv ----
// port-level assertions for the mac address lookup table
// assumes one core_clk domain with synchronous active-high rst
`timescale 1ns/10ps
module mac_lut_checker (
  input wire        core_clk,      // clock
  input wire        rst,           // reset
  input wire        s_axi_awready, // aw ready
  input wire        s_axi_wready,  // w ready
  input wire        s_axi_bvalid,  // b valid
  input wire        s_axi_bready,  // b ready
  input wire [1:0]  s_axi_bresp,   // b resp
  input wire        s_axi_arready, // ar ready
  input wire        s_axi_rvalid,  // r valid
  input wire        s_axi_rready,  // r ready
  input wire [31:0] s_axi_rdata,   // r data
  input wire        sa_req,        // source request
  input wire        sa_done,       // source done
  input wire        da_req,        // dest request
  input wire        da_done,       // dest done
  input wire        da_hit,        // dest hit
  input wire [6:0]  da_fwd         // dest forward map
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_AW_W_PAIR: assert property (s_axi_awready |-> s_axi_wready)
    else $error("write address and data ready split");
  AST_B_ANSWER: assert property (s_axi_awready |=> !s_axi_awready && s_axi_bvalid)
    else $error("write response not one cycle after transfer");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before ready");
  AST_B_CODE: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("write response code illegal");
  AST_R_ANSWER: assert property (s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one cycle after address");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before ready");
  AST_DA_BOUND: assert property ($rose(da_req) |-> ##[4:64] da_done)
    else $error("destination lookup not done in time");
  AST_SA_BOUND: assert property ($rose(sa_req) |-> ##[4:64] sa_done)
    else $error("source lookup not done in time");
  AST_DA_PULSE: assert property (da_done |=> !da_done)
    else $error("destination done longer than one cycle");
  AST_SA_PULSE: assert property (sa_done |=> !sa_done)
    else $error("source done longer than one cycle");
  AST_DA_HOLD: assert property (!da_done |-> $stable({da_hit, da_fwd}))
    else $error("destination result changed without done");
endmodule // mac_lut_checker
bind mac_address_lookup_table mac_lut_checker u_chk (.core_clk, .rst, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .sa_req, .sa_done, .da_req, .da_done, .da_hit, .da_fwd);
